// ### core/fsa_defs.svh
`ifndef FSA_DEFS_SVH
`define FSA_DEFS_SVH
// Operating-state code meaning locked
`define FSA_DPLL_LOCKED      3'h4
// Auto-reference field top pair marking three-input mode
`define FSA_AUTO_REF_TRIPLE  2'h3
// Input clock codes on the selected-reference field
`define FSA_REF_IN2          4'h2
`define FSA_REF_IN3          4'h3
`define FSA_REF_IN4          4'h4
`define FSA_REF_IN5          4'h5
`define FSA_REF_IN6          4'h6
`define FSA_REF_IN9          4'h9
// Consecutive good edges needed to qualify
`define FSA_QUAL_COUNT       7'h40
// Resample-clock edges per 2 kHz frame at 6.48 MHz, 19.44 MHz, 38.88 MHz
`define FSA_FRAME_648        15'h0CA8
`define FSA_FRAME_1944       15'h25F8
`define FSA_FRAME_3888       15'h4BF0
`endif

// ### core/fsa_pkg.sv
package fsa_pkg;
   typedef enum logic [1:0] {
      FSA_SRC_NONE = 2'b00,
      FSA_SRC_A    = 2'b01,
      FSA_SRC_B    = 2'b10,
      FSA_SRC_C    = 2'b11
   } fsa_src_t;
   typedef enum logic [1:0] {
      FSA_Q_IDLE = 2'b00,
      FSA_Q_HUNT = 2'b01,
      FSA_Q_OK   = 2'b10
   } fsa_qstate_t;
endpackage : fsa_pkg

// ### core/fsa_ext_sync_b.sv
`timescale 1ns/10ps
`default_nettype none
module fsa_ext_sync_b (
   input  wire logic mclk_in,
   input  wire logic arst_n_in,
   input  wire logic d_in,
   output var  logic q_out
);
   logic meta_q;
   // Two stages against metastability; first stage read only here
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= 1'b0;
         q_out  <= 1'b0;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule : fsa_ext_sync_b
`default_nettype wire

// ### core/fsa_frame_out.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsa_defs.svh"
module fsa_frame_out (
   input  wire logic mclk_in,
   input  wire logic arst_n_in,
   input  wire logic en_in,
   input  wire logic pulse_sel_in,
   input  wire logic invert_in,
   input  wire logic square_in,
   input  wire logic start_in,
   input  wire logic out3_rise_in,
   output var  logic frame_out
);
   logic pend_q;
   logic low_q;
   logic raw;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pend_q <= 1'b0;
         low_q  <= 1'b0;
      end else begin
         if (start_in) begin
            pend_q <= 1'b1;
         end else if (out3_rise_in && pend_q) begin
            pend_q <= 1'b0;
         end
         if (out3_rise_in) begin
            low_q <= pend_q;
         end
      end
   end
   // Square or pulse form, low for one period
   assign raw = pulse_sel_in ? !low_q : square_in;
   // Disabled output held low; polarity flip
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         frame_out <= 1'b0;
      end else begin
         frame_out <= en_in & (raw ^ invert_in);
      end
   end
endmodule : fsa_frame_out
`default_nettype wire

// ### core/fsa_align_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsa_defs.svh"
// Function
// - Each frame output driven only while enabled, else held low.
// - 8 kHz output is a square wave when pulse-select clear.
// - 8 kHz pulse form goes low one out-clock-three period per frame.
// - 8 kHz invert bit flips polarity of either form.
// - 2 kHz output is a square wave when pulse-select clear.
// - 2 kHz pulse form goes low one out-clock-three period per frame.
// - 2 kHz invert bit flips polarity of either form.
// - A sync fall while active realigns both the 8 kHz and 2 kHz outputs.
// - Alignment only when locked, enabled and qualified.
// - Enable bit clear disables all sync inputs.
// - Single-input manual mode uses sync A whenever locked.
// - Single-input auto uses A only when locked to named reference.
// - Association field maps inputs to sync A, B and C.
// - Three-input mode enables paired sync; otherwise disabled.
// - In three-input mode auto bit clears enable on reference change.
// - Locked means operating state reads 100.
// - Without external sync the generators free-run.
// - Sample on reference rising edge, phase field shifts timing.
// - Resample at 6.48 MHz, or reference rate when bit set.
// - Qualify after 64 consecutive on-boundary edges.
// - Disqualify on a single missing edge.
module fsa_align_gen (
   input  wire logic       mclk_in,
   input  wire logic       arst_n_in,
   input  wire logic       dpll_clk_in,
   input  wire logic       out_clock_three_in,
   input  wire logic       ref_clk_in,
   input  wire logic       resample_clk_in,
   input  wire logic       ext_sync_a_in,
   input  wire logic       ext_sync_b_in,
   input  wire logic       ext_sync_c_in,
   input  wire logic       frame8k_out_en_in,
   input  wire logic       frame2k_out_en_in,
   input  wire logic       frame8k_pulse_sel_in,
   input  wire logic       frame8k_invert_in,
   input  wire logic       frame2k_pulse_sel_in,
   input  wire logic       frame2k_invert_in,
   input  wire logic       ext_frame_enable_in,
   input  wire logic       ext_frame_auto_bit_in,
   input  wire logic [3:0] auto_ref_field_in,
   input  wire logic [2:0] sync_assoc_field_in,
   input  wire logic [3:0] selected_ref_in,
   input  wire logic [5:0] sync_phase_adj_in,
   input  wire logic       resample_rate_bit_in,
   input  wire logic       ref_is_3888_in,
   input  wire logic [2:0] main_dpll_state_in,
   output var  logic       frame8k_out,
   output var  logic       frame2k_out,
   output var  logic       ext_frame_clear_out,
   output var  logic       sync_qualified_out,
   output var  logic       sync_active_out,
   output var  logic [1:0] sync_source_out
);
   // Pin-side inputs, each through two flops
   logic [7:0] raw_pins;
   logic [7:0] pins_s;
   assign raw_pins = {dpll_clk_in, out_clock_three_in, ref_clk_in, resample_clk_in,
                      ext_sync_a_in, ext_sync_b_in, ext_sync_c_in, 1'b0};
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_sync
         fsa_ext_sync_b u_sync (
            .mclk_in   (mclk_in),
            .arst_n_in (arst_n_in),
            .d_in      (raw_pins[gi]),
            .q_out     (pins_s[gi])
         );
      end
   endgenerate

   logic dpll_s, out3_s, ref_s, rsmp_s;
   logic [2:0] sync_s;
   assign dpll_s = pins_s[7];
   assign out3_s = pins_s[6];
   assign ref_s  = pins_s[5];
   assign rsmp_s = pins_s[4];
   assign sync_s = pins_s[3:1];

   // Edge detect on the synchronised clocks
   logic dpll_d_q, out3_d_q, ref_d_q, rsmp_d_q;
   logic dpll_rise, out3_rise, ref_rise, ref_fall, rsmp_rise;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dpll_d_q <= 1'b0;
         out3_d_q <= 1'b0;
         ref_d_q  <= 1'b0;
         rsmp_d_q <= 1'b0;
      end else begin
         dpll_d_q <= dpll_s;
         out3_d_q <= out3_s;
         ref_d_q  <= ref_s;
         rsmp_d_q <= rsmp_s;
      end
   end
   assign dpll_rise = dpll_s & ~dpll_d_q;
   assign out3_rise = out3_s & ~out3_d_q;
   assign ref_rise  = ref_s & ~ref_d_q;
   assign ref_fall  = ~ref_s & ref_d_q;
   assign rsmp_rise = rsmp_s & ~rsmp_d_q;

   logic locked;
   assign locked = (main_dpll_state_in == `FSA_DPLL_LOCKED);

   // Source selection
   logic triple;
   fsa_pkg::fsa_src_t src;
   assign triple = (auto_ref_field_in[3:2] == `FSA_AUTO_REF_TRIPLE);
   always_comb begin
      src = fsa_pkg::FSA_SRC_NONE;
      // Enable clear or unlocked means no sync
      if (!ext_frame_enable_in || !locked) begin
         src = fsa_pkg::FSA_SRC_NONE;
      end else if (!triple) begin
         if (!ext_frame_auto_bit_in || selected_ref_in == auto_ref_field_in) begin
            src = fsa_pkg::FSA_SRC_A;
         end
      end else begin
         unique case (selected_ref_in)
            `FSA_REF_IN3: if (!sync_assoc_field_in[2] || !sync_assoc_field_in[0])
               src = fsa_pkg::FSA_SRC_A;
            `FSA_REF_IN5: if (!sync_assoc_field_in[2] || sync_assoc_field_in[0])
               src = fsa_pkg::FSA_SRC_A;
            `FSA_REF_IN4: if (!sync_assoc_field_in[2] || !sync_assoc_field_in[0])
               src = fsa_pkg::FSA_SRC_B;
            `FSA_REF_IN6: if (!sync_assoc_field_in[2] || sync_assoc_field_in[0])
               src = fsa_pkg::FSA_SRC_B;
            `FSA_REF_IN9: src = fsa_pkg::FSA_SRC_C;
            `FSA_REF_IN2: if (!sync_assoc_field_in[2] || sync_assoc_field_in[1])
               src = fsa_pkg::FSA_SRC_C;
            default: src = fsa_pkg::FSA_SRC_NONE;
         endcase
      end
   end

   // Clear enable pulse on reference change in three-input mode
   logic [3:0] ref_prev_q;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ref_prev_q          <= 4'h0_000;
         ext_frame_clear_out <= 1'b0;
      end else begin
         ref_prev_q          <= selected_ref_in;
         ext_frame_clear_out <= triple & ext_frame_auto_bit_in & ext_frame_enable_in
                                & (ref_prev_q != selected_ref_in);
      end
   end

   // Sample on reference edge chosen by the phase field
   logic sel_sync, samp_q, samp_d1_q;
   logic [1:0] phase;
   logic samp_edge;
   assign sel_sync = (src == fsa_pkg::FSA_SRC_B) ? sync_s[1] :
                     (src == fsa_pkg::FSA_SRC_C) ? sync_s[0] : sync_s[2];
   assign phase = (src == fsa_pkg::FSA_SRC_B) ? sync_phase_adj_in[3:2] :
                  (src == fsa_pkg::FSA_SRC_C) ? sync_phase_adj_in[5:4] :
                  sync_phase_adj_in[1:0];
   // Code 01 half early (falling edge), 1x one cycle late, 00 default
   assign samp_edge = (phase == 2'b01) ? ref_fall : ref_rise;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         samp_q    <= 1'b1;
         samp_d1_q <= 1'b1;
      end else if (samp_edge) begin
         samp_d1_q <= sel_sync;
         samp_q    <= phase[1] ? samp_d1_q : sel_sync;
      end
   end

   // Resample on resample clock or reference clock
   logic rs_tick, rs_q, rs_prev_q, sync_fall;
   logic [14:0] frame_len;
   assign rs_tick = resample_rate_bit_in ? ref_rise : rsmp_rise;
   assign frame_len = !resample_rate_bit_in ? `FSA_FRAME_648 :
                      (ref_is_3888_in ? `FSA_FRAME_3888 : `FSA_FRAME_1944);
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rs_q      <= 1'b1;
         rs_prev_q <= 1'b1;
      end else if (rs_tick) begin
         rs_q      <= samp_q;
         rs_prev_q <= rs_q;
      end
   end
   assign sync_fall = rs_tick & rs_prev_q & ~rs_q;

   // 64 on-boundary edges qualify, one miss disqualifies
   logic [14:0] rs_cnt_q;
   logic [6:0]  good_q;
   logic        boundary;
   fsa_pkg::fsa_qstate_t qst_q;
   assign boundary = rs_tick && (rs_cnt_q == frame_len - 15'h0_0001);
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rs_cnt_q <= 15'h0_0000;
         good_q   <= 7'h0_00;
         qst_q    <= fsa_pkg::FSA_Q_IDLE;
      end else if (src == fsa_pkg::FSA_SRC_NONE) begin
         good_q <= 7'h0_00;
         qst_q  <= fsa_pkg::FSA_Q_IDLE;
      end else if (rs_tick) begin
         rs_cnt_q <= (boundary || (qst_q == fsa_pkg::FSA_Q_IDLE && sync_fall)) ?
                     15'h0_0000 : rs_cnt_q + 15'h0_0001;
         unique case (qst_q)
            fsa_pkg::FSA_Q_IDLE: if (sync_fall) qst_q <= fsa_pkg::FSA_Q_HUNT;
            fsa_pkg::FSA_Q_HUNT: begin
               if (sync_fall && !boundary) begin
                  good_q <= 7'h0_00;
                  qst_q  <= fsa_pkg::FSA_Q_IDLE;
               end else if (boundary) begin
                  if (!sync_fall) begin
                     good_q <= 7'h0_00;
                     qst_q  <= fsa_pkg::FSA_Q_IDLE;
                  end else if (good_q == `FSA_QUAL_COUNT - 7'h0_01) begin
                     qst_q <= fsa_pkg::FSA_Q_OK;
                  end else begin
                     good_q <= good_q + 7'h0_01;
                  end
               end
            end
            fsa_pkg::FSA_Q_OK: if (boundary && !sync_fall) begin
               good_q <= 7'h0_00;
               qst_q  <= fsa_pkg::FSA_Q_IDLE;
            end
            default: qst_q <= fsa_pkg::FSA_Q_IDLE;
         endcase
      end
   end

   // Active only when locked, enabled and qualified
   logic active;
   assign active = (qst_q == fsa_pkg::FSA_Q_OK) && (src != fsa_pkg::FSA_SRC_NONE);
   assign sync_qualified_out = (qst_q == fsa_pkg::FSA_Q_OK);
   assign sync_active_out    = active;
   assign sync_source_out    = src;

   // 2 kHz alignment generator: four 8 kHz quarters of 2 phases each.
   // Counts 6.48 MHz DPLL edges whatever the resample rate, so the
   // output period never moves with the resample setting.
   logic [14:0] half_q;
   logic [2:0]  ph_q;
   logic        half_end, start8, start2, align;
   assign half_end = dpll_rise && (half_q == (`FSA_FRAME_648 >> 3) - 15'h0001);
   // Realign on sync fall; else free-run
   assign align = active && sync_fall;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         half_q <= 15'h0_0000;
         ph_q   <= 3'h0_0;
      end else if (align) begin
         half_q <= 15'h0_0000;
         ph_q   <= 3'h0_0;
      end else if (dpll_rise) begin
         half_q <= half_end ? 15'h0_0000 : half_q + 15'h0_0001;
         if (half_end) ph_q <= ph_q + 3'h0_1;
      end
   end
   assign start8 = align || (half_end && ph_q[0]);
   assign start2 = align || (half_end && ph_q == 3'h0_7);

   fsa_frame_out u_f8 (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .en_in        (frame8k_out_en_in),
      .pulse_sel_in (frame8k_pulse_sel_in),
      .invert_in    (frame8k_invert_in),
      .square_in    (ph_q[0]),
      .start_in     (start8),
      .out3_rise_in (out3_rise),
      .frame_out    (frame8k_out)
   );
   fsa_frame_out u_f2 (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .en_in        (frame2k_out_en_in),
      .pulse_sel_in (frame2k_pulse_sel_in),
      .invert_in    (frame2k_invert_in),
      .square_in    (ph_q[2]),
      .start_in     (start2),
      .out3_rise_in (out3_rise),
      .frame_out    (frame2k_out)
   );
endmodule : fsa_align_gen
`default_nettype wire

// ### tb/fsa_align_gen_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsa_defs.svh"
module fsa_align_gen_checker (
   input wire logic       mclk_in,
   input wire logic       arst_n_in,
   input wire logic       frame8k_out_en_in,
   input wire logic       frame2k_out_en_in,
   input wire logic       ext_frame_enable_in,
   input wire logic       ext_frame_auto_bit_in,
   input wire logic [3:0] auto_ref_field_in,
   input wire logic [3:0] selected_ref_in,
   input wire logic [2:0] main_dpll_state_in,
   input wire logic       frame8k_out,
   input wire logic       frame2k_out,
   input wire logic       ext_frame_clear_out,
   input wire logic       sync_qualified_out,
   input wire logic       sync_active_out,
   input wire logic [1:0] sync_source_out
);
   logic locked;
   logic triple;
   logic paired;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   // Mode decode; three steady cycles allow for any input staging
   assign locked = main_dpll_state_in == `FSA_DPLL_LOCKED;
   assign triple = auto_ref_field_in[3:2] == `FSA_AUTO_REF_TRIPLE;
   assign paired = selected_ref_in inside {`FSA_REF_IN2, `FSA_REF_IN3, `FSA_REF_IN4,
                                           `FSA_REF_IN5, `FSA_REF_IN6, `FSA_REF_IN9};
   sequence s_8k_off; !frame8k_out_en_in [*3]; endsequence
   sequence s_2k_off; !frame2k_out_en_in [*3]; endsequence
   sequence s_ext_off; !ext_frame_enable_in [*3]; endsequence
   sequence s_unlocked; !locked [*3]; endsequence
   sequence s_manual; (ext_frame_enable_in && locked && !triple && !ext_frame_auto_bit_in) [*3];
   endsequence
   sequence s_auto_miss;
      (ext_frame_enable_in && locked && !triple && ext_frame_auto_bit_in
       && selected_ref_in != auto_ref_field_in) [*3];
   endsequence
   sequence s_no_pair; (triple && !paired) [*3]; endsequence
   chk_8k_off_low: assert property (s_8k_off |-> !frame8k_out)
      else $error("frame8k output high while disabled");
   chk_2k_off_low: assert property (s_2k_off |-> !frame2k_out)
      else $error("frame2k output high while disabled");
   chk_disabled_none: assert property (s_ext_off |-> sync_source_out == 2'h0 && !sync_active_out)
      else $error("sync source used while external sync disabled");
   chk_unlocked_none: assert property (s_unlocked |-> sync_source_out == 2'h0)
      else $error("sync source used while dpll not locked");
   chk_active_needs_qual: assert property (
      sync_active_out |-> sync_qualified_out && sync_source_out != 2'h0
                          && locked && ext_frame_enable_in)
      else $error("alignment active without qualified source");
   chk_manual_uses_a: assert property (s_manual |-> sync_source_out == 2'h1)
      else $error("manual mode not using sync a");
   chk_auto_other_ref: assert property (s_auto_miss |-> sync_source_out == 2'h0)
      else $error("single auto mode used sync on foreign reference");
   chk_no_pair_none: assert property (s_no_pair |-> sync_source_out == 2'h0)
      else $error("three-input mode used sync on unpaired reference");
   chk_clear_one_cycle: assert property (ext_frame_clear_out |=> !ext_frame_clear_out)
      else $error("enable clear pulse longer than one cycle");
endmodule : fsa_align_gen_checker
bind fsa_align_gen fsa_align_gen_checker fsa_align_gen_checker_inst (
   .mclk_in(mclk_in), .arst_n_in(arst_n_in), .frame8k_out_en_in(frame8k_out_en_in),
   .frame2k_out_en_in(frame2k_out_en_in), .ext_frame_enable_in(ext_frame_enable_in),
   .ext_frame_auto_bit_in(ext_frame_auto_bit_in), .auto_ref_field_in(auto_ref_field_in),
   .selected_ref_in(selected_ref_in), .main_dpll_state_in(main_dpll_state_in),
   .frame8k_out(frame8k_out), .frame2k_out(frame2k_out),
   .ext_frame_clear_out(ext_frame_clear_out), .sync_qualified_out(sync_qualified_out),
   .sync_active_out(sync_active_out), .sync_source_out(sync_source_out));
`default_nettype wire

// ### tb/fsa_timing_card_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsa_timing_card_model #(
   parameter int REF_HALF_NS = 80,
   parameter int FRAME_REFS  = 810
) (
   input  wire logic run_in,
   output var  logic ref_clk_out,
   output var  logic sync_a_out,
   output var  logic sync_b_out,
   output var  logic sync_c_out
);
   int ref_cnt = 0;
   // Reference clock runs free, as a timing card's does
   initial begin
      ref_clk_out = 1'b0;
      forever #(REF_HALF_NS) ref_clk_out = ~ref_clk_out;
   end
   // Sync falls with the reference at each frame start; a halted card
   // holds the lines high, so no significant edge is seen
   always @(negedge ref_clk_out) begin
      ref_cnt <= (ref_cnt == FRAME_REFS - 1) ? 0 : ref_cnt + 1;
      sync_a_out <= !run_in || ref_cnt >= FRAME_REFS / 2;
      sync_b_out <= !run_in || ref_cnt >= FRAME_REFS / 2;
      sync_c_out <= !run_in || ref_cnt >= FRAME_REFS / 2;
   end
endmodule : fsa_timing_card_model
`default_nettype wire

// ### tb/test_frame_sync_align_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsa_defs.svh"
`define FSA_EQ(got, exp, msg) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("BAD %0t %s", $time, msg); \
      end \
   end
module test_frame_sync_align_gen;
   localparam int DPLL_NS = 40;
   localparam int OUT3_NS = 120;
   localparam realtime HALF8K = (`FSA_FRAME_648 / 8) * DPLL_NS;
   localparam realtime HALF2K = (`FSA_FRAME_648 / 2) * DPLL_NS;
   localparam logic [2:0] LK = `FSA_DPLL_LOCKED;
   localparam logic [1:0] SN = fsa_pkg::FSA_SRC_NONE;
   localparam logic [1:0] SA = fsa_pkg::FSA_SRC_A;
   localparam logic [1:0] SB = fsa_pkg::FSA_SRC_B;
   localparam logic [1:0] SC = fsa_pkg::FSA_SRC_C;
   logic mclk_in, arst_n_in, card_run, frame8k_out_en_in, frame2k_out_en_in;
   logic frame8k_pulse_sel_in, frame8k_invert_in, frame2k_pulse_sel_in, frame2k_invert_in;
   logic ext_frame_enable_in, ext_frame_auto_bit_in, resample_rate_bit_in, ref_is_3888_in;
   logic dpll_clk_in = 1'b0;
   logic out_clock_three_in = 1'b0;
   logic [3:0] auto_ref_field_in, selected_ref_in;
   logic [2:0] sync_assoc_field_in, main_dpll_state_in;
   logic [5:0] sync_phase_adj_in;
   logic ref_clk, sync_a, sync_b, sync_c;
   logic frame8k_out, frame2k_out, ext_frame_clear_out, sync_qualified_out, sync_active_out;
   logic [1:0] sync_source_out;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   fsa_align_gen fsa_align_gen_inst (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in), .dpll_clk_in(dpll_clk_in),
      .out_clock_three_in(out_clock_three_in), .ref_clk_in(ref_clk),
      .resample_clk_in(dpll_clk_in), .ext_sync_a_in(sync_a), .ext_sync_b_in(sync_b),
      .ext_sync_c_in(sync_c), .frame8k_out_en_in(frame8k_out_en_in),
      .frame2k_out_en_in(frame2k_out_en_in), .frame8k_pulse_sel_in(frame8k_pulse_sel_in),
      .frame8k_invert_in(frame8k_invert_in), .frame2k_pulse_sel_in(frame2k_pulse_sel_in),
      .frame2k_invert_in(frame2k_invert_in), .ext_frame_enable_in(ext_frame_enable_in),
      .ext_frame_auto_bit_in(ext_frame_auto_bit_in), .auto_ref_field_in(auto_ref_field_in),
      .sync_assoc_field_in(sync_assoc_field_in), .selected_ref_in(selected_ref_in),
      .sync_phase_adj_in(sync_phase_adj_in), .resample_rate_bit_in(resample_rate_bit_in),
      .ref_is_3888_in(ref_is_3888_in), .main_dpll_state_in(main_dpll_state_in),
      .frame8k_out(frame8k_out), .frame2k_out(frame2k_out),
      .ext_frame_clear_out(ext_frame_clear_out), .sync_qualified_out(sync_qualified_out),
      .sync_active_out(sync_active_out), .sync_source_out(sync_source_out));
   fsa_timing_card_model #(.REF_HALF_NS(80), .FRAME_REFS(810)) fsa_timing_card_model_inst (
      .run_in(card_run), .ref_clk_out(ref_clk), .sync_a_out(sync_a), .sync_b_out(sync_b),
      .sync_c_out(sync_c));
   // Pin clocks free-run out of phase with the system clock
   always #(DPLL_NS / 2) dpll_clk_in = ~dpll_clk_in;
   always #(OUT3_NS / 2) out_clock_three_in = ~out_clock_three_in;
   initial begin
      mclk_in = 1'b0;
      // Offset keeps pin clock edges off the sampling edge
      #2;
      forever #4 mclk_in = ~mclk_in;
   end
   // Hang guard sized above the longest frame measurements
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 99000) begin
         errors++;
         $display("BAD %0t run timed out", $time);
         test_done();
      end
   end
   task automatic test_done;
      if (errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : step
   function automatic logic near(input realtime a, input realtime b, input realtime tol);
      return (a >= b - tol) && (a <= b + tol);
   endfunction : near
   task automatic check_sel(input logic [2:0] st, input logic en, input logic au,
                            input logic [3:0] fld, input logic [2:0] as,
                            input logic [3:0] sel, input logic [1:0] exp);
      main_dpll_state_in = st;
      ext_frame_enable_in = en;
      ext_frame_auto_bit_in = au;
      auto_ref_field_in = fld;
      sync_assoc_field_in = as;
      selected_ref_in = sel;
      step(4);
      `FSA_EQ(sync_source_out, exp, "sync source selection")
   endtask : check_sel
   // Disabled outputs stay low even when inversion would raise them
   task automatic test_disabled;
      int highs;
      highs = 0;
      frame8k_invert_in = 1'b1;
      frame2k_invert_in = 1'b1;
      repeat (2100) begin
         step(1);
         highs += (frame8k_out !== 1'b0) + (frame2k_out !== 1'b0);
      end
      `FSA_EQ(highs, 0, "disabled frame output not low")
   endtask : test_disabled
   // Reference change in three-input mode; clear pulse only with the auto bit
   task automatic test_auto_clear(input logic au);
      int pulses;
      pulses = 0;
      check_sel(LK, 1'b1, au, 4'hC, 3'h0, 4'h3, SA);
      selected_ref_in = 4'h4;
      repeat (16) begin
         step(1);
         pulses += (ext_frame_clear_out === 1'b1);
      end
      `FSA_EQ(pulses, (au ? 1 : 0), "enable clear pulse count")
   endtask : test_auto_clear
   task automatic wait_lvl(input logic use2k, input logic lvl);
      int n;
      n = 0;
      while (((use2k ? frame2k_out : frame8k_out) !== lvl) && n < 40000) begin
         step(1);
         n++;
      end
   endtask : wait_lvl
   // Active phase width and, when asked, repeat period of one frame output
   task automatic test_frame(input logic use2k, input logic pul, input logic inv,
                             input realtime exp_w, input realtime exp_p);
      realtime t1, w, p;
      logic lvl;
      lvl = pul ? inv : 1'b1;
      p = 0;
      if (use2k) begin
         frame2k_pulse_sel_in = pul;
         frame2k_invert_in = inv;
         frame2k_out_en_in = 1'b1;
      end else begin
         frame8k_pulse_sel_in = pul;
         frame8k_invert_in = inv;
         frame8k_out_en_in = 1'b1;
      end
      step(4);
      wait_lvl(use2k, !lvl);
      wait_lvl(use2k, lvl);
      t1 = $realtime;
      wait_lvl(use2k, !lvl);
      w = $realtime - t1;
      if (exp_p > 0) begin
         wait_lvl(use2k, lvl);
         p = $realtime - t1;
      end
      `FSA_EQ(near(w, exp_w, 24), 1'b1, "frame active time")
      `FSA_EQ(near(p, exp_p, 16), 1'b1, "frame period")
   endtask : test_frame
   initial begin
      arst_n_in = 1'b0;
      card_run = 1'b1;
      {frame8k_out_en_in, frame2k_out_en_in, frame8k_pulse_sel_in, frame2k_pulse_sel_in} = '0;
      {frame8k_invert_in, frame2k_invert_in, ext_frame_enable_in, ext_frame_auto_bit_in} = '0;
      {resample_rate_bit_in, ref_is_3888_in} = '0;
      auto_ref_field_in = 4'h3;
      selected_ref_in = 4'h3;
      sync_assoc_field_in = 3'h0;
      main_dpll_state_in = 3'h2;
      sync_phase_adj_in = 6'h00;
      step(20);
      arst_n_in = 1'b1;
      step(2);
      test_disabled();
      check_sel(LK, 1'b0, 1'b0, 4'h3, 3'h0, 4'h3, SN);
      check_sel(3'h3, 1'b1, 1'b0, 4'h3, 3'h0, 4'h3, SN);
      check_sel(LK, 1'b1, 1'b0, 4'h3, 3'h0, 4'h9, SA);
      check_sel(LK, 1'b1, 1'b1, 4'h5, 3'h0, 4'h5, SA);
      check_sel(LK, 1'b1, 1'b1, 4'h5, 3'h0, 4'h3, SN);
      check_sel(LK, 1'b1, 1'b0, 4'hC, 3'h0, 4'h5, SA);
      check_sel(LK, 1'b1, 1'b0, 4'hC, 3'h0, 4'h6, SB);
      check_sel(LK, 1'b1, 1'b0, 4'hC, 3'h0, 4'h9, SC);
      check_sel(LK, 1'b1, 1'b1, 4'hC, 3'h4, 4'h4, SB);
      check_sel(LK, 1'b1, 1'b1, 4'hC, 3'h4, 4'h5, SN);
      check_sel(LK, 1'b1, 1'b0, 4'hC, 3'h5, 4'h5, SA);
      check_sel(LK, 1'b1, 1'b0, 4'hC, 3'h5, 4'h3, SN);
      check_sel(LK, 1'b1, 1'b0, 4'hC, 3'h0, 4'h7, SN);
      check_sel(LK, 1'b1, 1'b0, 4'hC, 3'h6, 4'h2, SC);
      check_sel(3'h2, 1'b1, 1'b0, 4'hC, 3'h0, 4'h3, SN);
      test_auto_clear(1'b1);
      test_auto_clear(1'b0);
      check_sel(LK, 1'b1, 1'b0, 4'h3, 3'h0, 4'h3, SA);
      test_frame(1'b0, 1'b0, 1'b0, HALF8K, 2 * HALF8K);
      test_frame(1'b0, 1'b1, 1'b0, OUT3_NS, 2 * HALF8K);
      test_frame(1'b0, 1'b1, 1'b1, OUT3_NS, 2 * HALF8K);
      test_frame(1'b1, 1'b1, 1'b1, OUT3_NS, 0);
      test_frame(1'b1, 1'b0, 1'b0, HALF2K, 2 * HALF2K);
      // Far fewer than 64 frames have passed, so no qualification yet
      `FSA_EQ(sync_qualified_out, 1'b0, "qualified too early")
      `FSA_EQ(sync_active_out, 1'b0, "aligning without qualification")
      test_done();
   end
endmodule : test_frame_sync_align_gen
`default_nettype wire
